// *** rpa_far_pcs.sv ***
// Far-end model: remote PCS sending lane markers on all twenty lanes.
`default_nettype none
module rpa_far_pcs
  import rpa_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      rstn,
  input  wire logic                      run,
  input  wire logic [PW-1:0]             period,
  input  wire logic [NLANE-1:0]          bad_form,
  input  wire logic [NLANE-1:0]          drop,
  input  wire logic [NLANE-1:0]          unlock,
  output var  logic [NLANE-1:0]          word_valid,
  output var  logic [NLANE-1:0]          marker_seen,
  output var  logic [NLANE-1:0]          marker_ok,
  output var  logic [NLANE-1:0][IDW-1:0] marker_lane_id,
  output var  logic [NLANE-1:0]          hdr_lock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PW-1:0] cnt_reg;
  logic          mk;
  // ---------------------------------------------------------------
  // Marker timing
  // ---------------------------------------------------------------
  // Word counter; a marker follows every period plain words.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else if (run) begin
      cnt_reg <= (cnt_reg == period) ? '0 : cnt_reg + 1'b1;
    end
  end
  // Lane p carries logical lane 19-p; ids off a marker are junk.
  always_comb begin
    mk          = run && (cnt_reg == '0);
    word_valid  = {NLANE{run}};
    hdr_lock    = {NLANE{run}} & ~unlock;
    marker_seen = {NLANE{mk}} & ~drop & ~unlock;
    marker_ok   = marker_seen & ~bad_form;
    for (int p = 0; p < NLANE; p++) begin
      marker_lane_id[p] = IDW'(NLANE - 1 - p) ^ {IDW{~mk}};
    end
  end
endmodule
`default_nettype wire

// *** rpa_lane.sv ***
// Module: marker spacing, form and sync tracking of one lane.
`default_nettype none
module rpa_lane
  import rpa_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rstn,
  rpa_lane_if.lane  lf
);
  rpa_lane_st_t s_reg;
  rpa_lane_st_t s_next;
  logic         good_sp;
  logic         mk_err;

  // Next state: word count, marker checks, sync.
  always_comb begin
    s_next = s_reg;
    // The first marker after lock has no earlier marker to be measured from.
    good_sp = ~s_reg.got_mk | (s_reg.wcnt == lf.period);
    mk_err = lf.mk_seen & (~lf.mk_ok | ~good_sp);
    s_next.lock = lf.lock_in;                           // [R7]
    s_next.bad_pulse = lf.mk_seen & ~lf.mk_ok;          // [R4]
    s_next.err_pulse = lf.mk_seen & mk_err;
    if (lf.mk_seen) begin
      s_next.wcnt = '0;
      if (mk_err) begin
        s_next.sp_err = ~good_sp;                       // [R2]
        if (s_reg.ecnt != RPT_LIMIT) begin
          s_next.ecnt = s_reg.ecnt + 3'h1;
        end
      end else begin
        s_next.sp_err = 1'b0;
        s_next.ecnt = '0;
        s_next.got_mk = 1'b1;
        s_next.id = lf.mk_id;
      end
    end else if (lf.word_valid && s_reg.wcnt != '1) begin
      s_next.wcnt = s_reg.wcnt + 16'h0001;
      // A marker overdue also counts as wrong spacing.
      if (s_reg.got_mk && s_reg.wcnt >= lf.period) begin
        s_next.sp_err = 1'b1;                           // [R2]
      end
    end
    if (!lf.lock_in) begin
      s_next.wcnt = '0;
      s_next.ecnt = '0;
      s_next.got_mk = 1'b0;
      s_next.sp_err = 1'b0;
    end
    s_next.rp_err = (s_next.ecnt == RPT_LIMIT);         // [R3]
    s_next.synced = lf.lock_in & s_next.got_mk;         // [R12]
    s_next.sync_err = ~s_next.synced;                   // [R1]
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;                                      // [R14]
    end else begin
      s_reg <= s_next;
    end
  end

  assign lf.block_lock = s_reg.lock;
  assign lf.synced     = s_reg.synced;
  assign lf.sync_err   = s_reg.sync_err;
  assign lf.sp_err     = s_reg.sp_err;
  assign lf.rp_err     = s_reg.rp_err;
  assign lf.bad_pulse  = s_reg.bad_pulse;
  assign lf.err_pulse  = s_reg.err_pulse;
  assign lf.id         = s_reg.id;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  malformed_pulse_a: assert property ( // [R4]
    rstn && lf.mk_seen && !lf.mk_ok |=> lf.bad_pulse)
    else $error("malformed marker not flagged");
  malformed_cause_a: assert property ( // [R4]
    lf.bad_pulse |-> $past(lf.mk_seen && !lf.mk_ok))
    else $error("malformed pulse without cause");
  repeat_after_four_a: assert property ( // [R3]
    s_reg.ecnt == 3'h3 && lf.lock_in && mk_err |=> lf.rp_err)
    else $error("fourth marker error not reported");
  spacing_bad_a: assert property ( // [R2]
    rstn && lf.lock_in && lf.mk_seen && lf.mk_ok && !good_sp |=> lf.sp_err)
    else $error("marker spacing error missed");
  lock_loss_sync_a: assert property ( // [R1]
    rstn && !lf.lock_in |=> lf.sync_err && !lf.synced)
    else $error("sync error not raised on lock loss");
  block_lock_follow_a: assert property ( // [R7]
    rstn |=> lf.block_lock == $past(lf.lock_in))
    else $error("block lock does not follow");
endmodule
`default_nettype wire

// *** rpa_lane_if.sv ***
// Interface: signals between the top and one lane tracker.
`default_nettype none
interface rpa_lane_if;
  import rpa_pkg::*;
  logic           word_valid;
  logic           mk_seen;
  logic           mk_ok;
  logic [IDW-1:0] mk_id;
  logic           lock_in;
  logic [PW-1:0]  period;
  logic           block_lock;
  logic           synced;
  logic           sync_err;
  logic           sp_err;
  logic           rp_err;
  logic           bad_pulse;
  logic           err_pulse;
  logic [IDW-1:0] id;
  modport lane (input word_valid, mk_seen, mk_ok, mk_id, lock_in,
                input period, output block_lock, synced, sync_err,
                output sp_err, rp_err, bad_pulse, err_pulse, id);
  modport top (output word_valid, mk_seen, mk_ok, mk_id, lock_in,
               output period, input block_lock, synced, sync_err,
               input sp_err, rp_err, bad_pulse, err_pulse, id);
endinterface
`default_nettype wire

// *** rpa_pkg.sv ***
// Package: constants and state types of the lane status block.
`default_nettype none
package rpa_pkg;
  localparam int NLANE = 20;
  localparam int IDW   = 5;
  localparam int PW    = 16;
  localparam int AW    = 8;
  localparam int DW    = 32;
  localparam int NEV   = 3;
  // Marker errors in a row before the repeat error is raised.
  localparam logic [2:0] RPT_LIMIT = 3'h4;
  // ---------------------------------------------------------------
  // Register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CFG  = 8'h00;
  localparam logic [AW-1:0] OFS_STAT = 8'h04;
  localparam logic [AW-1:0] OFS_INTS = 8'h08;
  localparam logic [AW-1:0] OFS_INTM = 8'h0C;
  localparam logic [PW-1:0] PERIOD_RST = 16'h3FFF;
  localparam logic [NEV-1:0] INTM_RST  = 3'h0;
  // Interrupt status bit positions.
  localparam int EV_MISAL = 0;
  localparam int EV_ALOST = 1;
  localparam int EV_RFLT  = 2;
  // Lane tracker state.
  typedef struct packed {
    logic [PW-1:0]  wcnt;
    logic [2:0]     ecnt;
    logic           got_mk;
    logic           lock;
    logic           synced;
    logic           sync_err;
    logic           sp_err;
    logic           rp_err;
    logic           bad_pulse;
    logic           err_pulse;
    logic [IDW-1:0] id;
  } rpa_lane_st_t;
endpackage
`default_nettype wire

// *** rpa_status.sv ***
// Module: receive PCS lane alignment status with register port.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`default_nettype none
// Summary of operation
// R1: Per lane, sync error high while word sync lost or no marker seen.
// R2: Per lane, spacing error held while markers not one period (period-minus-one plus one words) apart.
// R3: Per lane, repeat error held after four marker errors in a row.
// R4: Per lane, malformed marker flag pulses one cycle per bad marker.
// R5: Aligned high only when all lanes aligned and de-skewed.
// R6: PCS status high only while aligned and not in high bit error rate.
// R7: Per lane block lock level follows the lane's 66b lock state.
// R8: Alignment error high on alignment failure or loss; code raises it only once aligned once, and clears it when no lane is synced.
// R9: Misaligned pulse one meta-frame after bad marker, once aligned once.
// R10: Remote fault level follows the detected remote fault condition.
// R11: Twenty 5-bit buses name physical lane of each logical lane.
// R12: Lane synced set after word sync and a received marker.
// R13: Local fault high on internal or received local fault.
// R14: All status synchronous to core clock, inactive during reset; local fault is held high during reset.
module rpa_status
  import rpa_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  input  wire logic [NLANE-1:0]            word_valid,
  input  wire logic [NLANE-1:0]            marker_seen,
  input  wire logic [NLANE-1:0]            marker_ok,
  input  wire logic [NLANE-1:0][IDW-1:0]   marker_lane_id,
  input  wire logic [NLANE-1:0]            hdr_lock,
  input  wire logic                        hi_ber,
  input  wire logic                        remote_fault_in,
  input  wire logic                        rx_local_fault_in,
  input  wire logic [AW-1:0]               reg_addr,
  input  wire logic [DW-1:0]               reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output var  logic [DW-1:0]               reg_rdata,
  output var  logic                        irq,
  output var  logic [NLANE-1:0]            lane_sync_error,
  output var  logic [NLANE-1:0]            lane_synced,
  output var  logic [NLANE-1:0]            lane_marker_spacing_error,
  output var  logic [NLANE-1:0]            lane_marker_repeat_error,
  output var  logic [NLANE-1:0]            lane_marker_malformed_pulse,
  output var  logic [NLANE-1:0]            lane_block_lock,
  output var  logic                        all_aligned,
  output var  logic                        pcs_status,
  output var  logic                        alignment_error,
  output var  logic                        misaligned_pulse,
  output var  logic                        remote_fault,
  output var  logic                        local_fault,
  output var  logic [NLANE-1:0][IDW-1:0]   physical_lane_of
);
  // ---------------------------------------------------------------
  // Types and state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PW-1:0]             marker_period_minus_one;
    logic [NEV-1:0]            int_st;
    logic [NEV-1:0]            int_mask;
    logic [DW-1:0]             rdata;
    logic                      irq;
    logic                      aligned;
    logic                      ever;
    logic                      aligned_err;
    logic                      status;
    logic                      rfault;
    logic                      lfault;
    logic                      misal;
    logic                      pend;
    logic [PW-1:0]             mf_cnt;
    logic [NLANE-1:0][IDW-1:0] map;
  } rpa_top_st_t;

  rpa_top_st_t          s_reg;
  rpa_top_st_t          s_next;
  logic [NLANE-1:0]     synced_w;
  logic [NLANE-1:0]     sp_w;
  logic [NLANE-1:0]     rp_w;
  logic [NLANE-1:0]     errp_w;
  logic [NLANE-1:0]     found_w;
  logic [NLANE-1:0][IDW-1:0] id_w;
  logic [NLANE-1:0][IDW-1:0] phys_w;
  logic [NEV-1:0]       ev;
  logic                 can_align;

  // ---------------------------------------------------------------
  // Lane trackers
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NLANE; g++) begin : g_lane
    rpa_lane_if lif ();
    // Lane inputs come from datapath logic on this clock.
    assign lif.word_valid = word_valid[g];
    assign lif.mk_seen    = marker_seen[g];
    assign lif.mk_ok      = marker_ok[g];
    assign lif.mk_id      = marker_lane_id[g];
    assign lif.lock_in    = hdr_lock[g];
    assign lif.period     = s_reg.marker_period_minus_one;
    rpa_lane u_lane (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .lf      (lif.lane)
    );
    // Lane flops drive the per-lane outputs directly.
    assign lane_sync_error[g]             = lif.sync_err;    // [R1]
    assign lane_synced[g]                 = lif.synced;      // [R12]
    assign lane_marker_spacing_error[g]   = lif.sp_err;      // [R2]
    assign lane_marker_repeat_error[g]    = lif.rp_err;      // [R3]
    assign lane_marker_malformed_pulse[g] = lif.bad_pulse;   // [R4]
    assign lane_block_lock[g]             = lif.block_lock;  // [R7]
    assign synced_w[g] = lif.synced;
    assign sp_w[g]     = lif.sp_err;
    assign rp_w[g]     = lif.rp_err;
    assign errp_w[g]   = lif.err_pulse;
    assign id_w[g]     = lif.id;
  end

  // ---------------------------------------------------------------
  // Lane mapping
  // ---------------------------------------------------------------
  // Finds the synced physical lane whose marker names logical lane.
  function automatic logic [IDW:0] find_lane(
    input logic [NLANE-1:0][IDW-1:0] ids,
    input logic [NLANE-1:0]          ok,
    input logic [IDW-1:0]            logical
  );
    logic [IDW:0] r;
    r = '0;
    for (int p = 0; p < NLANE; p++) begin
      if (ok[p] && ids[p] == logical && !r[IDW]) begin
        r = {1'b1, p[IDW-1:0]};
      end
    end
    return r;
  endfunction

  // Map each logical lane to its physical lane.
  always_comb begin
    for (int l = 0; l < NLANE; l++) begin
      {found_w[l], phys_w[l]} =
        find_lane(id_w, synced_w, l[IDW-1:0]);             // [R11]
    end
  end

  // All lanes locked with markers, every logical lane present, no
  // spacing or repeat trouble: lanes are aligned and de-skewed.
  assign can_align = (&synced_w) & (&found_w) & ~(|sp_w) & ~(|rp_w);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.rdata = '0;
    s_next.misal = 1'b0;
    s_next.map = phys_w;                                   // [R11]
    s_next.aligned = can_align;                            // [R5]
    // Markers correct on all lanes at least once arms the check.
    if (can_align) begin
      s_next.ever = 1'b1;
    end else if (synced_w == '0) begin
      s_next.ever = 1'b0;
    end
    s_next.aligned_err = s_next.ever & ~can_align;         // [R8]
    s_next.status = can_align & ~hi_ber;                   // [R6]
    s_next.rfault = remote_fault_in;                       // [R10]
    s_next.lfault = ~can_align | rx_local_fault_in;        // [R5] [R13]
    // Bad marker after alignment: pulse one meta-frame later.
    if (s_reg.pend) begin
      if (word_valid[0]) begin
        if (s_reg.mf_cnt == '0) begin
          s_next.misal = 1'b1;                             // [R9]
          s_next.pend = 1'b0;
        end else begin
          s_next.mf_cnt = s_reg.mf_cnt - 16'h0001;
        end
      end
    end else if (s_reg.ever && (|errp_w)) begin
      s_next.pend = 1'b1;                                  // [R9]
      s_next.mf_cnt = s_reg.marker_period_minus_one;
    end
    // Register writes.
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CFG:  s_next.marker_period_minus_one = reg_wdata[PW-1:0];
        OFS_INTS: s_next.int_st = s_reg.int_st & ~reg_wdata[NEV-1:0];
        OFS_INTM: s_next.int_mask = reg_wdata[NEV-1:0];
        default:  s_next.int_mask = s_reg.int_mask;
      endcase
    end
    // Events set after the clear, so a set wins.
    s_next.int_st = s_next.int_st | ev;
    s_next.irq = |(s_next.int_st & s_next.int_mask);
    // Register reads, data in the next cycle.
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CFG:  s_next.rdata = {16'h0000, s_reg.marker_period_minus_one};
        OFS_STAT: s_next.rdata = {26'h000_0000, s_reg.lfault,
                                  s_reg.rfault, s_reg.aligned_err,
                                  s_reg.status, s_reg.aligned,
                                  s_reg.ever};
        OFS_INTS: s_next.rdata = {29'h0000_0000, s_reg.int_st};
        OFS_INTM: s_next.rdata = {29'h0000_0000, s_reg.int_mask};
        default:  s_next.rdata = '0;
      endcase
    end
  end

  // Interrupt events: misalignment, alignment lost, remote fault.
  always_comb begin
    ev = '0;
    ev[EV_MISAL] = s_next.misal;
    ev[EV_ALOST] = s_reg.aligned & ~can_align;
    ev[EV_RFLT]  = remote_fault_in & ~s_reg.rfault;
  end

  // State register; reset leaves every status inactive except local fault, which reset sets high.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;                                         // [R14]
      s_reg.marker_period_minus_one <= PERIOD_RST;
      s_reg.int_mask <= INTM_RST;
      s_reg.lfault <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata        = s_reg.rdata;
  assign irq              = s_reg.irq;
  assign all_aligned      = s_reg.aligned;
  assign pcs_status       = s_reg.status;
  assign alignment_error  = s_reg.aligned_err;
  assign misaligned_pulse = s_reg.misal;
  assign remote_fault     = s_reg.rfault;
  assign local_fault      = s_reg.lfault;
  assign physical_lane_of = s_reg.map;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence armed_error_s;
    !s_reg.pend && s_reg.ever && (|errp_w);
  endsequence
  sequence pend_wait_s;
    s_reg.pend && !misaligned_pulse;
  endsequence

  aligned_needs_sync_a: assert property ( // [R5]
    all_aligned |-> $past(&synced_w))
    else $error("aligned without all lanes synced");
  hi_ber_status_a: assert property ( // [R6]
    hi_ber |=> !pcs_status)
    else $error("status high during high error rate");
  status_aligned_a: assert property ( // [R6]
    pcs_status |-> all_aligned)
    else $error("status high while not aligned");
  align_err_loss_a: assert property ( // [R8]
    all_aligned && !can_align |=> alignment_error)
    else $error("alignment loss not flagged");
  misal_arm_a: assert property ( // [R9]
    armed_error_s |=> pend_wait_s)
    else $error("misalignment not scheduled");
  misal_never_a: assert property ( // [R9]
    !s_reg.ever && !s_reg.pend |=> !misaligned_pulse)
    else $error("misalignment before first alignment");
  misal_single_a: assert property ( // [R9]
    misaligned_pulse |=> !misaligned_pulse || $past(word_valid[0]))
    else $error("misalignment pulse stretched");
  remote_fault_a: assert property ( // [R10]
    rstn |=> remote_fault == $past(remote_fault_in))
    else $error("remote fault does not follow");
  local_fault_a: assert property ( // [R13]
    rx_local_fault_in |=> local_fault)
    else $error("local fault not raised");
  irq_level_a: assert property (
    irq |-> |(s_reg.int_st & s_reg.int_mask))
    else $error("interrupt without unmasked status");
endmodule
`default_nettype wire

// *** tb_rx_pcs_lane_align_status.sv ***
// Testbench: self-checking bench of the lane alignment status block.
`default_nettype none
module tb_rx_pcs_lane_align_status
  import rpa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 6;
  logic                      clk_sys = 1'b0;
  logic                      rstn = 1'b0;
  logic                      run = 1'b0;
  logic                      hi_ber = 1'b0;
  logic                      rf_in = 1'b0;
  logic                      lf_in = 1'b0;
  logic [NLANE-1:0]          bad_form = '0;
  logic [NLANE-1:0]          drop = '0;
  logic [NLANE-1:0]          unlock = '0;
  logic [AW-1:0]             reg_addr = '0;
  logic [DW-1:0]             reg_wdata = '0;
  logic                      reg_wr = 1'b0;
  logic                      reg_rd = 1'b0;
  logic [DW-1:0]             reg_rdata;
  logic                      irq;
  logic [NLANE-1:0]          wv, ms, mo, hl, sync_err, synced;
  logic [NLANE-1:0]          sp_err, rp_err, mal, blk;
  logic [NLANE-1:0][IDW-1:0] mid, map;
  logic                      aligned, status, al_err, mis, rflt, lflt;
  logic [DW-1:0]             v;
  logic [5:0]                rows [4];
  int                        err_total = 0;
  int                        samples_checked = 0;
  int                        n_mal, n_mis, d;

  rpa_far_pcs far (.clk_sys(clk_sys), .rstn(rstn), .run(run),
    .period(PW'(P)), .bad_form(bad_form), .drop(drop), .unlock(unlock),
    .word_valid(wv), .marker_seen(ms), .marker_ok(mo),
    .marker_lane_id(mid), .hdr_lock(hl));

  rpa_status dut (.clk_sys(clk_sys), .rstn(rstn), .word_valid(wv),
    .marker_seen(ms), .marker_ok(mo), .marker_lane_id(mid),
    .hdr_lock(hl), .hi_ber(hi_ber), .remote_fault_in(rf_in),
    .rx_local_fault_in(lf_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .lane_sync_error(sync_err),
    .lane_synced(synced), .lane_marker_spacing_error(sp_err),
    .lane_marker_repeat_error(rp_err),
    .lane_marker_malformed_pulse(mal), .lane_block_lock(blk),
    .all_aligned(aligned), .pcs_status(status),
    .alignment_error(al_err), .misaligned_pulse(mis),
    .remote_fault(rflt), .local_fault(lflt), .physical_lane_of(map));

  // Clock of 100 MHz.
  always #5 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Compares one value and reports a mismatch.
  task automatic chk(input string name, input logic [DW-1:0] exp,
                     input logic [DW-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask
  // Waits n edges, then lets the edge's updates settle.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // One-cycle register write.
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] dat);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= dat;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  // One-cycle register read; data taken in the following cycle.
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] q);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    q = reg_rdata;
  endtask
  // Waits until lane l shows a marker and the design has taken it.
  task automatic wait_mk(input int l);
    for (int i = 0; i < 4 * P; i++) begin
      tick(1);
      if (ms[l] === 1'b1) break;
    end
    tick(1);
  endtask
  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of a few hundred cycles.
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    // Rows: hi_ber, remote in, local in, then status, remote, local.
    rows = '{6'b000_100, 6'b100_000, 6'b010_110, 6'b001_101};
    tick(2);
    chk("reset local fault", 32'h0000_0001, 32'(lflt));
    chk("reset aligned", 32'h0000_0000, 32'(aligned));
    chk("reset synced", 32'h0000_0000, 32'(synced));
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(OFS_CFG, v);
    chk("period reset", 32'(PERIOD_RST), v);
    rd(OFS_INTM, v);
    chk("mask reset", 32'(INTM_RST), v);
    rd(8'h10, v);
    chk("unmapped read", 32'h0000_0000, v);
    chk("sync error no marker", 32'h000F_FFFF, 32'(sync_err));
    wr(OFS_CFG, 32'(P));
    @(posedge clk_sys);
    run <= 1'b1;
    tick(4 * (P + 1) + 4);
    chk("synced", 32'h000F_FFFF, 32'(synced));
    chk("sync error", 32'h0000_0000, 32'(sync_err));
    chk("block lock", 32'h000F_FFFF, 32'(blk));
    chk("aligned", 32'h0000_0001, 32'(aligned));
    chk("alignment error", 32'h0000_0000, 32'(al_err));
    for (int l = 0; l < NLANE; l++) begin
      if (synced[NLANE - 1 - l] === 1'b1) begin
        chk("lane map", 32'(NLANE - 1 - l), 32'(map[l]));
      end
    end
    // Ordinary cases: status inputs against status levels.
    for (int r = 0; r < 4; r++) begin
      @(posedge clk_sys);
      {hi_ber, rf_in, lf_in} <= rows[r][5:3];
      tick(3);
      chk("pcs status", 32'(rows[r][2]), 32'(status));
      chk("remote fault", 32'(rows[r][1]), 32'(rflt));
      chk("local fault", 32'(rows[r][0]), 32'(lflt));
      @(posedge clk_sys);
      {hi_ber, rf_in, lf_in} <= 3'h0;
    end
    // Remote fault rise left a sticky event; mask it in, then clear.
    wr(OFS_INTM, 32'h0000_0004);
    tick(1);
    chk("irq masked in", 32'h0000_0001, 32'(irq));
    wr(OFS_INTS, 32'h0000_0004);
    tick(1);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    // One malformed marker on lane 3: one pulse, then one misalign.
    @(posedge clk_sys);
    bad_form[3] <= 1'b1;
    wait_mk(3);
    bad_form[3] <= 1'b0;
    n_mal = 0;
    n_mis = 0;
    d = 0;
    for (int i = 0; i < 3 * (P + 1); i++) begin
      if (mal[3] === 1'b1) n_mal++;
      if (mis === 1'b1) begin
        n_mis++;
        d = i;
      end
      tick(1);
    end
    chk("malformed pulses", 32'h0000_0001, 32'(n_mal));
    chk("misaligned pulses", 32'h0000_0001, 32'(n_mis));
    chk("misaligned delay", 32'h0000_0001,
        32'(d >= P && d <= P + 3));
    // Four malformed markers in a row on lane 5.
    @(posedge clk_sys);
    bad_form[5] <= 1'b1;
    repeat (3) wait_mk(5);
    chk("repeat after three", 32'h0000_0000, 32'(rp_err[5]));
    wait_mk(5);
    chk("repeat after four", 32'h0000_0001, 32'(rp_err[5]));
    @(posedge clk_sys);
    bad_form[5] <= 1'b0;
    wait_mk(5);
    chk("repeat cleared", 32'h0000_0000, 32'(rp_err[5]));
    // A missing marker on lane 6 upsets the spacing.
    @(posedge clk_sys);
    drop[6] <= 1'b1;
    wait_mk(0);
    chk("spacing raised", 32'h0000_0001, 32'(sp_err[6]));
    drop[6] <= 1'b0;
    wait_mk(6);
    chk("spacing held", 32'h0000_0001, 32'(sp_err[6]));
    wait_mk(6);
    chk("spacing cleared", 32'h0000_0000, 32'(sp_err[6]));
    // Lane 0 loses block lock: alignment lost.
    @(posedge clk_sys);
    unlock[0] <= 1'b1;
    tick(3);
    chk("lock lost", 32'h0000_0000, 32'(blk[0]));
    chk("sync error lost", 32'h0000_0001, 32'(sync_err[0]));
    chk("aligned lost", 32'h0000_0000, 32'(aligned));
    chk("alignment loss", 32'h0000_0001, 32'(al_err));
    chk("local fault lost", 32'h0000_0001, 32'(lflt));
    chk("status lost", 32'h0000_0000, 32'(status));
    rd(OFS_INTS, v);
    chk("alignment lost event", 32'h0000_0002, v & 32'h0000_0002);
    // Reset in mid-run.
    @(posedge clk_sys);
    rstn <= 1'b0;
    tick(1);
    chk("rerun synced", 32'h0000_0000, 32'(synced));
    chk("rerun alignment error", 32'h0000_0000, 32'(al_err));
    // Release again with lock restored; lanes take markers anew.
    @(posedge clk_sys);
    rstn   <= 1'b1;
    unlock <= '0;
    tick(2 * (P + 1));
    chk("rerun synced again", 32'h000F_FFFF, 32'(synced));
    wrap_up();
  end
endmodule
`default_nettype wire
